/* rtl/psq_program_sequencer.v */
// Overview of operation
// (RQ1) system clock divides into four phases; four phases make one instruction cycle
// (RQ2) counter advances at start of fetch phase, next instruction fetched then
// (RQ3) decode and execute run in phases two to four, overlapped with next fetch
// (RQ4) jumps, calls and other non-sequential flow take two cycles; others one
// (RQ5) with rc oscillator, pin outputs fetch phase clock, quarter rate, 1:3 duty
// (RQ6) counter increments by one per instruction unless flow is non-sequential
// (RQ7) taken skip discards prefetched instruction and runs a dummy cycle
// (RQ8) software reads and writes only the low counter byte
// (RQ9) low byte write branches within current 256-word page, adds dummy cycle
// (RQ10) jump, call, interrupt, reset load full address; jump/call from instruction field
// (RQ11) return stack holds six values; stack and pointer invisible to software
// (RQ12) call or interrupt acknowledge pushes current counter onto stack
// (RQ13) subroutine or interrupt return pops latest stacked value into counter
// (RQ14) reset puts stack pointer at empty top position
// (RQ15) full stack withholds interrupt acknowledge until a return frees a level
// (RQ16) call on full stack still executes and overflows the stack
// (RQ17) after reset execution starts at address zero
// (RQ18) acknowledged external interrupt vectors to address four
// (RQ19) acknowledged first timer overflow vectors to address eight
// (RQ20) acknowledged second timer overflow vectors to address twelve
// (RQ21) taken skip leaves counter two beyond the skip instruction
`include "psq_map.vh"
`default_nettype none
module psq_program_sequencer #(
	parameter PC_W  = `PSQ_PC_W,
	parameter DEPTH = `PSQ_STACK_DEPTH
) (
	input  wire             core_clk,
	input  wire             sys_rst,
	input  wire             rc_osc_sel,
	input  wire             op_jump,
	input  wire             op_call,
	input  wire             op_subroutine_return,
	input  wire             op_interrupt_return,
	input  wire             op_skip_taken,
	input  wire [PC_W-1:0]  op_target,
	input  wire             pcl_wr,
	input  wire [7:0]       pcl_wdata,
	input  wire             irq_ext,
	input  wire             irq_tmr0,
	input  wire             irq_tmr1,
	output reg  [PC_W-1:0]  fetch_addr_ff,
	output reg              fetch_strobe_ff,
	output reg              exec_valid_ff,
	output reg              dummy_cycle_ff,
	output reg  [7:0]       program_counter_low_byte_ff,
	output reg              int_ack_ff,
	output reg  [1:0]       int_ack_src_ff,
	output reg              stack_full_ff,
	output reg              second_oscillator_pin_ff,
	output reg  [3:0]       phase_onehot_ff
);
	// ----------------------------------------
	// phase sequencer
	// ----------------------------------------
	localparam [3:0] PH_FETCH = 4'h1;
	localparam [3:0] PH_EX2   = 4'h2;
	localparam [3:0] PH_EX3   = 4'h4;
	localparam [3:0] PH_EX4   = 4'h8;

	reg  [3:0]      phase_ff;
	reg  [3:0]      nxt_phase;
	reg  [PC_W-1:0] pc_ff;
	reg  [PC_W-1:0] nxt_pc;
	reg  [PC_W-1:0] stack_ff [0:DEPTH-1];
	reg  [2:0]      sp_ff;
	reg  [2:0]      nxt_sp;
	reg             flush_ff;
	reg             nxt_flush;
	reg             pend_ext_ff;
	reg             pend_t0_ff;
	reg             pend_t1_ff;
	reg             do_push;
	reg  [PC_W-1:0] push_val;
	reg             nxt_ack;
	reg  [1:0]      nxt_src;
	integer         i;

	// stack depth as a pointer-wide constant; the pointer saturates above it on overflow
	localparam [31:0] DEPTH_W = DEPTH;
	localparam [2:0]  SP_FULL = DEPTH_W[2:0];

	wire       end_cycle = phase_ff[3];
	wire       full      = (sp_ff >= SP_FULL);
	// pop index clamps to the deepest entry after an overflow left the pointer past it
	wire [2:0] top_idx   = (sp_ff == 3'h0) ? 3'h0 :
		((sp_ff > SP_FULL) ? (SP_FULL - 3'h1) : (sp_ff - 3'h1));
	wire do_pop    = op_subroutine_return | op_interrupt_return;

	function [PC_W-1:0] vec_of;
		input [1:0] src;
		begin
			case (src)
				2'h0:    vec_of = `PSQ_VEC_EXT;
				2'h1:    vec_of = `PSQ_VEC_TMR0;
				default: vec_of = `PSQ_VEC_TMR1;
			endcase
		end
	endfunction

	always @* begin
		case (phase_ff)
			PH_FETCH: nxt_phase = PH_EX2;
			PH_EX2:   nxt_phase = PH_EX3;
			PH_EX3:   nxt_phase = PH_EX4;
			PH_EX4:   nxt_phase = PH_FETCH; // see (RQ1)
			default:  nxt_phase = PH_FETCH;
		endcase
	end

	// ----------------------------------------
	// next counter, stack and interrupt decision
	// ----------------------------------------
	always @* begin
		nxt_pc    = pc_ff;
		nxt_sp    = sp_ff;
		nxt_flush = flush_ff;
		do_push   = 1'b0;
		push_val  = pc_ff;
		nxt_ack   = 1'b0;
		nxt_src   = 2'h0;
		if (end_cycle) begin
			nxt_flush = 1'b0;
			nxt_pc    = pc_ff + 1'b1; // see (RQ6) (RQ2)
			if (flush_ff) begin
				nxt_pc = pc_ff + 1'b1; // see (RQ4)
			end else if (op_call) begin
				do_push   = 1'b1; // see (RQ12) (RQ16)
				nxt_sp    = (sp_ff == 3'h7) ? sp_ff : sp_ff + 1'b1;
				nxt_pc    = op_target; // see (RQ10)
				nxt_flush = 1'b1;
			end else if (op_jump) begin
				nxt_pc    = op_target; // see (RQ10)
				nxt_flush = 1'b1; // see (RQ4)
			end else if (do_pop) begin
				if (sp_ff != 3'h0)
					nxt_sp = sp_ff - 1'b1;
				nxt_pc    = stack_ff[top_idx]; // see (RQ13)
				nxt_flush = 1'b1;
			end else if (pcl_wr) begin
				nxt_pc    = {pc_ff[PC_W-1:8], pcl_wdata}; // see (RQ9) (RQ8)
				nxt_flush = 1'b1;
			end else if (op_skip_taken) begin
				nxt_pc    = pc_ff + 1'b1; // see (RQ21)
				nxt_flush = 1'b1; // see (RQ7)
			end else if ((pend_ext_ff | pend_t0_ff | pend_t1_ff) && !full) begin // see (RQ15)
				nxt_ack   = 1'b1;
				nxt_src   = pend_ext_ff ? 2'h0 : (pend_t0_ff ? 2'h1 : 2'h2);
				do_push   = 1'b1; // see (RQ12)
				push_val  = pc_ff;
				nxt_sp    = sp_ff + 1'b1;
				nxt_pc    = vec_of(nxt_src); // see (RQ18) (RQ19) (RQ20)
				nxt_flush = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase_ff                    <= PH_FETCH;
			pc_ff                       <= `PSQ_VEC_RESET; // see (RQ17)
			sp_ff                       <= 3'h0; // see (RQ14)
			flush_ff                    <= 1'b0;
			pend_ext_ff                 <= 1'b0;
			pend_t0_ff                  <= 1'b0;
			pend_t1_ff                  <= 1'b0;
			fetch_addr_ff               <= `PSQ_VEC_RESET;
			fetch_strobe_ff             <= 1'b0;
			exec_valid_ff               <= 1'b0;
			dummy_cycle_ff              <= 1'b0;
			program_counter_low_byte_ff <= 8'h00;
			int_ack_ff                  <= 1'b0;
			int_ack_src_ff              <= 2'h0;
			stack_full_ff               <= 1'b0;
			second_oscillator_pin_ff    <= 1'b0;
			phase_onehot_ff             <= 4'h0;
			for (i = 0; i < DEPTH; i = i + 1)
				stack_ff[i] <= {PC_W{1'b0}};
		end else begin
			phase_ff <= nxt_phase;
			pc_ff    <= nxt_pc;
			sp_ff    <= nxt_sp;
			flush_ff <= nxt_flush;
			if (do_push && sp_ff < SP_FULL)
				stack_ff[sp_ff] <= push_val;
			else if (do_push)
				stack_ff[DEPTH-1] <= push_val; // see (RQ16)
			// set wins over acknowledge clear; requests latched while full
			pend_ext_ff <= irq_ext  | (pend_ext_ff & ~(nxt_ack && nxt_src == 2'h0)); // see (RQ15)
			pend_t0_ff  <= irq_tmr0 | (pend_t0_ff & ~(nxt_ack && nxt_src == 2'h1));
			pend_t1_ff  <= irq_tmr1 | (pend_t1_ff & ~(nxt_ack && nxt_src == 2'h2));
			fetch_strobe_ff <= nxt_phase[0]; // see (RQ2)
			if (end_cycle)
				fetch_addr_ff <= nxt_pc;
			exec_valid_ff  <= nxt_phase[1] & ~flush_ff; // see (RQ3)
			dummy_cycle_ff <= end_cycle ? nxt_flush : dummy_cycle_ff; // see (RQ7)
			program_counter_low_byte_ff <= nxt_pc[7:0]; // see (RQ8)
			int_ack_ff     <= nxt_ack;
			int_ack_src_ff <= nxt_ack ? nxt_src : int_ack_src_ff;
			stack_full_ff  <= (nxt_sp >= SP_FULL); // see (RQ11)
			second_oscillator_pin_ff <= rc_osc_sel & nxt_phase[0]; // see (RQ5)
			phase_onehot_ff <= nxt_phase;
		end
	end
endmodule
`default_nettype wire

/* inc/psq_map.vh */
`ifndef PSQ_MAP_VH
`define PSQ_MAP_VH
// ----------------------------------------
// widths and sizes
// ----------------------------------------
`define PSQ_PC_W        12
`define PSQ_STACK_DEPTH 6
`define PSQ_SP_W        3
`define PSQ_PHASE_W     2
// ----------------------------------------
// vectors
// ----------------------------------------
`define PSQ_VEC_RESET   12'h000
`define PSQ_VEC_EXT     12'h004
`define PSQ_VEC_TMR0    12'h008
`define PSQ_VEC_TMR1    12'h00C
// ----------------------------------------
// phase codes
// ----------------------------------------
`define PSQ_PH_FETCH    2'h0
`define PSQ_PH_LAST     2'h3
`endif

/* sim/psq_program_sequencer_chk.sv */
`default_nettype none
module psq_chk #(
	parameter PC_W = 12
) (
	input wire logic		core_clk,
	input wire logic		sys_rst,
	input wire logic		op_jump,
	input wire logic		op_call,
	input wire logic		op_subroutine_return,
	input wire logic		op_interrupt_return,
	input wire logic		op_skip_taken,
	input wire logic [PC_W-1:0]	op_target,
	input wire logic		pcl_wr,
	input wire logic [7:0]	pcl_wdata,
	input wire logic [PC_W-1:0]	fetch_addr_ff,
	input wire logic		fetch_strobe_ff,
	input wire logic		dummy_cycle_ff,
	input wire logic		int_ack_ff,
	input wire logic [1:0]	int_ack_src_ff,
	input wire logic		stack_full_ff,
	input wire logic [3:0]	phase_onehot_ff
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	wire [3:0]	ph = phase_onehot_ff;
	wire		take = ph[3] && !dummy_cycle_ff;
	wire		flow = op_jump || op_call || op_subroutine_return || op_interrupt_return;
	property p_ph; ph == 4'h1 |=> ph == 4'h2 ##1 ph == 4'h4 ##1 ph == 4'h8 ##1 ph == 4'h1; endproperty
	property p_st; fetch_strobe_ff == ph[0]; endproperty
	property p_hold; ph[2:0] != 3'h0 |=> $stable(fetch_addr_ff); endproperty
	property p_br;
		take && (op_jump || op_call) |=> fetch_addr_ff == $past(op_target) && dummy_cycle_ff
			##4 !dummy_cycle_ff;
	endproperty
	property p_pcl;
		take && pcl_wr && !flow |=> fetch_addr_ff[7:0] == $past(pcl_wdata) && dummy_cycle_ff;
	endproperty
	property p_skp;
		take && op_skip_taken && !flow && !pcl_wr
			|=> dummy_cycle_ff && fetch_addr_ff == $past(fetch_addr_ff) + 12'h001;
	endproperty
	property p_full; stack_full_ff && ph[3] |=> !int_ack_ff; endproperty
	property p_ack; int_ack_ff |-> ph == 4'h1 && fetch_addr_ff == {int_ack_src_ff + 2'h1, 2'h0}; endproperty
	a_ph: assert property (p_ph) else $error("phase order");
	a_st: assert property (p_st) else $error("fetch strobe");
	a_hold: assert property (p_hold) else $error("fetch address moved");
	a_br: assert property (p_br) else $error("branch target");
	a_pcl: assert property (p_pcl) else $error("low byte write");
	a_skp: assert property (p_skp) else $error("skip");
	a_full: assert property (p_full) else $error("ack on full stack");
	a_ack: assert property (p_ack) else $error("vector");
	c_ack: cover property (int_ack_ff);
	c_full: cover property (stack_full_ff);
	c_skp: cover property (take && op_skip_taken);
endmodule
bind psq_program_sequencer psq_chk #(.PC_W(PC_W)) u_chk (.*);
`default_nettype wire

/* sim/tb_program_sequencer.sv */
`default_nettype none
module tb_program_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	logic		core_clk = 1'b0, sys_rst = 1'b1, rc_osc_sel = 1'b1, irq_ext = 1'b0;
	logic		irq_tmr0 = 1'b0, irq_tmr1 = 1'b0, op_call, op_jump, op_subroutine_return;
	logic		op_interrupt_return, pcl_wr, op_skip_taken, fetch_strobe_ff, exec_valid_ff;
	logic		dummy_cycle_ff, int_ack_ff, stack_full_ff, second_oscillator_pin_ff;
	logic [5:0]	ctl = 6'h00;
	logic [11:0]	op_target = 12'h000, fetch_addr_ff, a;
	logic [7:0]	pcl_wdata = 8'h00, program_counter_low_byte_ff;
	logic [1:0]	int_ack_src_ff;
	logic [3:0]	phase_onehot_ff;
	int		errors = 0, check_count = 0, n;
	assign {op_call, op_jump, op_subroutine_return, op_interrupt_return, pcl_wr, op_skip_taken} = ctl;
	psq_program_sequencer uut (.*);
	initial forever #2.5 core_clk = ~core_clk;
	task automatic stop_test;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [11:0] g, input logic [11:0] e);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wt(input bit ack);
		for (int k = 0; k < 40; k++) begin
			@(negedge core_clk);
			if (ack ? int_ack_ff === 1'b1 : phase_onehot_ff === 4'h4 && dummy_cycle_ff === 1'b0)
				return;
		end
		errors++;
		stop_test;
	endtask
	task automatic op(input logic [5:0] f, input logic [11:0] t);
		wt(1'b0);
		@(posedge core_clk);
		ctl <= f;
		op_target <= t;
		pcl_wdata <= t[7:0];
		@(posedge core_clk) ctl <= 6'h00;
		@(negedge core_clk);
	endtask
	task automatic t_reset;
		@(negedge core_clk);
		chk(fetch_addr_ff, 12'h000);
		chk({11'h0, stack_full_ff}, 12'h000);
		n = 0;
		repeat (8) @(negedge core_clk) n += second_oscillator_pin_ff;
		chk(12'(n), 12'h002);
	endtask
	task automatic t_flow;
		op(6'h10, 12'h5A3);
		chk(fetch_addr_ff, 12'h5A3);
		chk({11'h0, dummy_cycle_ff}, 12'h001);
		@(negedge core_clk);
		chk({11'h0, exec_valid_ff}, 12'h000);
		repeat (3) @(negedge core_clk);
		chk(fetch_addr_ff, 12'h5A4);
		chk({4'h0, program_counter_low_byte_ff}, 12'h0A4);
		@(negedge core_clk);
		chk({11'h0, exec_valid_ff}, 12'h001);
		repeat (3) @(negedge core_clk);
		op(6'h02, 12'h010);
		chk(fetch_addr_ff, 12'h510);
		repeat (4) @(negedge core_clk);
		a = fetch_addr_ff;
		op(6'h01, 12'h000);
		chk(fetch_addr_ff, a + 12'h001);
		chk({11'h0, dummy_cycle_ff}, 12'h001);
	endtask
	task automatic t_stack;
		for (int i = 0; i < 6; i++) begin
			repeat (4) @(negedge core_clk);
			a = fetch_addr_ff;
			op(6'h20, 12'h200);
		end
		chk({11'h0, stack_full_ff}, 12'h001);
		@(posedge core_clk) irq_ext <= 1'b1;
		@(posedge core_clk) irq_ext <= 1'b0;
		n = 0;
		repeat (12) @(negedge core_clk) n += int_ack_ff;
		chk(12'(n), 12'h000);
		for (int i = 0; i < 3; i++) begin
			op(i ? 6'h04 : 6'h08, 12'h000);
			if (i == 0)
				chk(fetch_addr_ff, a);
			@(posedge core_clk) {irq_tmr1, irq_tmr0} <= 2'(i);
			@(posedge core_clk) {irq_tmr1, irq_tmr0} <= 2'h0;
			wt(1'b1);
			chk(fetch_addr_ff, 12'(4 * i + 4));
			chk({10'h0, int_ack_src_ff}, 12'(i));
		end
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_reset;
		t_flow;
		t_stack;
		stop_test;
	end
endmodule
`default_nettype wire
